/* File: pkg/spie_defines.svh */
// constants of the spi status, error and request block
`ifndef SPIE_DEFINES_SVH
`define SPIE_DEFINES_SVH

`define SPIE_DIV_DEFAULT 8
`define SPIE_DIV_MIN 8
`define SPIE_DIV_MAX 512
`define SPIE_STEP_ZERO 4'h0
`define SPIE_STEP_ONE 4'h1
`define SPIE_STEP_LAST 4'hF
`define SPIE_HCNT_ZERO 8'h00
`define SPIE_HCNT_ONE 8'h01
`define SPIE_CAP_BIT1 3'h6
`define SPIE_CAP_LAST 3'h7
`define SPIE_CNT_ZERO 3'h0
`define SPIE_CNT_ONE 3'h1
`define SPIE_BYTE_ZERO 8'h00
`define SPIE_SS_IDLE 3'h7

`endif

/* File: pkg/spie_pkg.sv */
// types of the spi status, error and request block
package spie_pkg;

  typedef logic [7:0] spie_byte_t;

  typedef enum logic
  {
    SPIE_IDLE = 1'b0,
    SPIE_XFER = 1'b1
  } spie_mode_t;

  typedef struct packed {
    logic en;
    logic master_select_alias;
    logic cpol;
    logic cpha;
    logic txie;
    logic rxie;
    logic error_irq_enable;
    logic select_conflict_enable;
    logic tx_empty;
    logic rx_full;
    logic ovr;
    logic select_conflict_flag;
    logic rx_arm;
    logic ovr_arm;
    logic select_conflict_flag_arm;
    spie_byte_t rx_data;
    spie_byte_t tx_buf;
    spie_byte_t txsh;
    spie_byte_t rxsh;
    spie_byte_t slv_word;
    spie_mode_t mode;
    logic [7:0] hcnt;
    logic [3:0] step;
    logic slv_act;
    logic slv_done;
    logic [2:0] ss_s;
    logic [1:0] sck_s;
    logic [1:0] miso_s;
    logic [2:0] done_s;
    logic [2:0] bit1_s;
    logic sck_out;
    logic sck_oe;
    logic mosi_out;
    logic mosi_oe;
    logic miso_oe;
    logic tx_irq;
    logic rx_irq;
  } spie_core_t;

  typedef struct packed {
    spie_byte_t sh;
    spie_byte_t word;
    logic done_tgl;
    logic bit1_tgl;
  } spie_link_t;

endpackage

/* File: hdl/spie_link.sv */
// slave shift logic on the incoming serial clock
`timescale 1ns/10ps
`default_nettype none
`include "spie_defines.svh"

module spie_link
(
  input wire logic sck,
  input wire logic cap_inv,
  input wire logic nrst,
  input wire logic clr,
  input wire logic mosi,
  input wire spie_pkg::spie_byte_t tx_word,
  output logic miso,
  output logic done_tgl,
  output logic bit1_tgl,
  output spie_pkg::spie_byte_t rx_word
);
  import spie_pkg::*;

  logic cap_clk;
  logic [2:0] cnt;
  spie_link_t lk;
  spie_link_t next_lk;

  // capture edge is rising when polarity equals phase; both change on any control write, enabled or not
  assign cap_clk = sck ^ cap_inv;

  // deselect clears the bit count at once, so edges seen while deselected are void
  always_ff @(posedge cap_clk or posedge clr)
  begin
    if (clr)
      cnt <= `SPIE_CNT_ZERO;
    else
      cnt <= cnt + `SPIE_CNT_ONE;
  end

  always_comb
  begin
    next_lk = lk;
    next_lk.sh = {lk.sh[6:0], mosi};
    if (cnt == `SPIE_CAP_BIT1)
      next_lk.bit1_tgl = ~lk.bit1_tgl;
    if (cnt == `SPIE_CAP_LAST)
    begin
      next_lk.word = {lk.sh[6:0], mosi};
      next_lk.done_tgl = ~lk.done_tgl;
    end
  end

  // toggles keep system reset only, so a deselect never fakes an event
  always_ff @(posedge cap_clk or negedge nrst)
  begin
    if (!nrst)
      lk <= '{sh: `SPIE_BYTE_ZERO, word: `SPIE_BYTE_ZERO, done_tgl: 1'b0, bit1_tgl: 1'b0};
    else
      lk <= next_lk;
  end

  // launch edge presents the next bit; the word is stable for the whole transfer
  always_ff @(negedge cap_clk or posedge clr)
  begin
    if (clr)
      miso <= 1'b0;
    else
      miso <= tx_word[~cnt];
  end

  assign done_tgl = lk.done_tgl;
  assign bit1_tgl = lk.bit1_tgl;
  assign rx_word = lk.word;

endmodule
`default_nettype wire

/* File: hdl/spie_core.sv */
// spi status flags, error detection and request generation
//
// Notes on behaviour
// - idle end: refill empty flag within two cycles
// - busy slave: no load until transfer ends
// - overrun when unread at bit one capture
// - during overrun new bytes are dropped
// - overrun clears by status read, data read
// - one error enable gates both error sources
// - master drives clock and out, slave drives in
// - conflict: slave deselected mid-transfer, master selected
// - conflict flag sets only while enabled
// - master conflict disables, empties, clears, releases pins
// - transfer span depends on clock phase
// - phase zero: select alone starts a transfer
// - conflict keeps master select bit unchanged
// - slave conflict flags and ends the transfer, never disables
// - deselected slave floats output, ignores clocks
// - conflict clears by status read, control write
// - full clears by status read, data read
// - only a data write clears empty flag
// - transmit request needs enable, empty, module on
// - receive request ignores module enable
// - completed byte into receive register sets full
// - byte into shift register sets empty
// - module off: partial reset, empty flag set, other flags kept
`timescale 1ns/10ps
`default_nettype none
`include "spie_defines.svh"

module spie_core
#(
  parameter int DIV = `SPIE_DIV_DEFAULT
)
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CTRL_WR,
  input wire logic CTRL_ENABLE,
  input wire logic CTRL_MASTER,
  input wire logic CTRL_CPOL,
  input wire logic CTRL_CPHA,
  input wire logic CTRL_TXIE,
  input wire logic CTRL_RXIE,
  input wire logic STAT_WR,
  input wire logic STAT_ERROR_IRQ_ENABLE,
  input wire logic STAT_SELECT_CONFLICT_ENABLE,
  input wire logic STAT_RD,
  input wire logic DATA_RD,
  input wire logic DATA_WR,
  input wire spie_pkg::spie_byte_t DATA_WDATA,
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE,
  input wire logic MOSI_IN,
  output logic MOSI_OUT,
  output logic MOSI_OE,
  input wire logic MISO_IN,
  output logic MISO_OUT,
  output logic MISO_OE,
  input wire logic SS_N,
  output logic TX_EMPTY,
  output logic RX_FULL,
  output logic OVERRUN,
  output logic SELECT_CONFLICT,
  output logic MODULE_ENABLE,
  output logic MASTER_SELECT,
  output spie_pkg::spie_byte_t RX_DATA,
  output logic TX_IRQ,
  output logic RX_ERR_IRQ
);
  import spie_pkg::*;

  localparam logic [7:0] HALF_LAST = 8'(DIV / 2 - 1);

  generate
    if (DIV < `SPIE_DIV_MIN || DIV > `SPIE_DIV_MAX || (DIV % 2) != 0)
    begin : g_bad_div
      $error("spie_core: DIV must be even and within the supported range");
    end
  endgenerate

  spie_core_t st;
  spie_core_t next_st;

  logic ss;
  logic ss_fall;
  logic sck_idle;
  logic done_ev;
  logic bit1_ev;
  logic slave_on;
  logic m_fault;
  logic s_fault;
  logic fault_cond;
  logic half_end;
  logic capture;
  logic [2:0] cap_idx;
  logic link_clr;
  logic link_miso;
  logic link_done;
  logic link_bit1;
  spie_byte_t link_word;

  // deselect or leaving slave mode aborts the link side at once
  assign link_clr = SS_N | ~(st.en & ~st.master_select_alias);

  spie_link u_link
  (
    .sck(SCK_IN),
    .cap_inv(st.cpol ^ st.cpha),
    .nrst(NRST),
    .clr(link_clr),
    .mosi(MOSI_IN),
    .tx_word(st.slv_word),
    .miso(link_miso),
    .done_tgl(link_done),
    .bit1_tgl(link_bit1),
    .rx_word(link_word)
  );

  always_comb
  begin
    next_st = st;
    ss = st.ss_s[1];
    ss_fall = st.ss_s[2] & ~st.ss_s[1];
    sck_idle = (st.sck_s[1] == st.cpol);
    done_ev = st.done_s[2] ^ st.done_s[1];
    bit1_ev = st.bit1_s[2] ^ st.bit1_s[1];
    slave_on = st.en & ~st.master_select_alias;
    m_fault = st.en & st.master_select_alias & ~ss;
    s_fault = slave_on & st.slv_act & ss;
    fault_cond = (st.master_select_alias & ~ss) | s_fault;
    half_end = (st.hcnt == HALF_LAST);
    capture = (st.step[0] == st.cpha);
    cap_idx = st.step[3:1];

    // pin and event synchronisers
    next_st.ss_s = {st.ss_s[1:0], SS_N};
    next_st.sck_s = {st.sck_s[0], SCK_IN};
    next_st.miso_s = {st.miso_s[0], MISO_IN};
    next_st.done_s = {st.done_s[1:0], link_done};
    next_st.bit1_s = {st.bit1_s[1:0], link_bit1};

    // control writes; the master select bit is never touched by hardware
    if (CTRL_WR)
    begin
      next_st.en = CTRL_ENABLE;
      next_st.master_select_alias = CTRL_MASTER;
      next_st.cpol = CTRL_CPOL;
      next_st.cpha = CTRL_CPHA;
      next_st.txie = CTRL_TXIE;
      next_st.rxie = CTRL_RXIE;
    end
    if (STAT_WR)
    begin
      next_st.error_irq_enable = STAT_ERROR_IRQ_ENABLE;
      next_st.select_conflict_enable = STAT_SELECT_CONFLICT_ENABLE;
    end

    // two-step clears: status read arms, second access completes
    if (STAT_RD)
    begin
      next_st.rx_arm = st.rx_full;
      next_st.ovr_arm = st.ovr;
      next_st.select_conflict_flag_arm = st.select_conflict_flag & ~fault_cond;
    end
    if (DATA_RD && st.rx_arm)
    begin
      next_st.rx_full = 1'b0;
      next_st.rx_arm = 1'b0;
    end
    if (DATA_RD && st.ovr_arm)
    begin
      next_st.ovr = 1'b0;
      next_st.ovr_arm = 1'b0;
    end
    if (CTRL_WR && st.select_conflict_flag_arm && !fault_cond)
      next_st.select_conflict_flag = 1'b0;
    if (CTRL_WR || fault_cond)
      next_st.select_conflict_flag_arm = 1'b0;

    // master engine
    if (st.en && st.master_select_alias)
    begin
      next_st.sck_oe = 1'b1;
      next_st.mosi_oe = 1'b1;
      next_st.miso_oe = 1'b0;
      if (st.mode == SPIE_IDLE)
      begin
        next_st.sck_out = st.cpol;
        if (!st.tx_empty)
        begin
          next_st.txsh = st.tx_buf;
          next_st.tx_empty = 1'b1;
          next_st.mode = SPIE_XFER;
          next_st.hcnt = `SPIE_HCNT_ZERO;
          next_st.step = `SPIE_STEP_ZERO;
          if (!st.cpha)
            next_st.mosi_out = st.tx_buf[7];
        end
      end
      else if (!half_end)
        next_st.hcnt = st.hcnt + `SPIE_HCNT_ONE;
      else
      begin
        next_st.hcnt = `SPIE_HCNT_ZERO;
        next_st.sck_out = ~st.sck_out;
        next_st.step = st.step + `SPIE_STEP_ONE;
        if (capture)
        begin
          next_st.rxsh = {st.rxsh[6:0], st.miso_s[1]};
          if (cap_idx == `SPIE_CAP_BIT1 && next_st.rx_full)
            next_st.ovr = 1'b1;
          if (cap_idx == `SPIE_CAP_LAST && !next_st.ovr)
          begin
            next_st.rx_data = {st.rxsh[6:0], st.miso_s[1]};
            next_st.rx_full = 1'b1;
          end
        end
        else
        begin
          next_st.mosi_out = st.cpha ? st.txsh[7] : st.txsh[6];
          next_st.txsh = {st.txsh[6:0], 1'b0};
        end
        // a queued byte loads on the following cycle
        if (st.step == `SPIE_STEP_LAST)
          next_st.mode = SPIE_IDLE;
      end
    end

    // slave side
    if (slave_on)
    begin
      next_st.sck_oe = 1'b0;
      next_st.mosi_oe = 1'b0;
      next_st.miso_oe = ~ss;
      next_st.mode = SPIE_IDLE;
      if (st.cpha ? (!ss && !sck_idle) : ss_fall)
        next_st.slv_act = 1'b1;
      if (done_ev)
        next_st.slv_done = 1'b1;
      if (st.slv_done && sck_idle)
      begin
        next_st.slv_act = 1'b0;
        next_st.slv_done = 1'b0;
      end
      // the shadow word may change only between transfers
      if (!st.slv_act && !st.tx_empty)
      begin
        next_st.slv_word = st.tx_buf;
        next_st.tx_empty = 1'b1;
      end
      if (bit1_ev && next_st.rx_full)
        next_st.ovr = 1'b1;
      if (done_ev && !next_st.ovr)
      begin
        next_st.rx_data = link_word;
        next_st.rx_full = 1'b1;
      end
      if (s_fault)
      begin
        if (st.select_conflict_enable)
          next_st.select_conflict_flag = 1'b1;
        next_st.slv_act = 1'b0;
        next_st.slv_done = 1'b0;
      end
    end

    // a data write clears the empty flag and nothing else does
    if (DATA_WR)
    begin
      next_st.tx_buf = DATA_WDATA;
      next_st.tx_empty = 1'b0;
    end

    // partial reset while disabled; empty flag sets, other flags and control bits survive
    if (!st.en)
    begin
      next_st.tx_empty = 1'b1;
      next_st.mode = SPIE_IDLE;
      next_st.hcnt = `SPIE_HCNT_ZERO;
      next_st.step = `SPIE_STEP_ZERO;
      next_st.txsh = `SPIE_BYTE_ZERO;
      next_st.rxsh = `SPIE_BYTE_ZERO;
      next_st.slv_act = 1'b0;
      next_st.slv_done = 1'b0;
      next_st.sck_out = st.cpol;
      next_st.mosi_out = 1'b0;
      next_st.sck_oe = 1'b0;
      next_st.mosi_oe = 1'b0;
      next_st.miso_oe = 1'b0;
    end

    // master conflict shuts the module down; a software enable in the same cycle loses
    if (m_fault && st.select_conflict_enable)
    begin
      next_st.select_conflict_flag = 1'b1;
      next_st.en = 1'b0;
      next_st.tx_empty = 1'b1;
      next_st.mode = SPIE_IDLE;
      next_st.hcnt = `SPIE_HCNT_ZERO;
      next_st.step = `SPIE_STEP_ZERO;
      next_st.txsh = `SPIE_BYTE_ZERO;
      next_st.rxsh = `SPIE_BYTE_ZERO;
      next_st.sck_out = st.cpol;
      next_st.sck_oe = 1'b0;
      next_st.mosi_oe = 1'b0;
      next_st.miso_oe = 1'b0;
    end

    // a control write moves the pins in the same cycle, so no driver outlives its mode
    if (!next_st.en || !next_st.master_select_alias)
    begin
      next_st.sck_oe = 1'b0;
      next_st.mosi_oe = 1'b0;
    end
    if (!next_st.en || next_st.master_select_alias)
      next_st.miso_oe = 1'b0;
    if (!next_st.en)
      next_st.tx_empty = 1'b1;

    // requests follow the flags as levels
    next_st.tx_irq = next_st.txie & next_st.tx_empty & next_st.en;
    next_st.rx_irq = (next_st.rxie & next_st.rx_full)
      | (next_st.error_irq_enable & (next_st.ovr | next_st.select_conflict_flag));
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      st <= '{tx_empty: 1'b1, ss_s: `SPIE_SS_IDLE, mode: SPIE_IDLE, default: '0};
    else
      st <= next_st;
  end

  assign SCK_OUT = st.sck_out;
  assign SCK_OE = st.sck_oe;
  assign MOSI_OUT = st.mosi_out;
  assign MOSI_OE = st.mosi_oe;
  assign MISO_OUT = link_miso;
  assign MISO_OE = st.miso_oe;
  assign TX_EMPTY = st.tx_empty;
  assign RX_FULL = st.rx_full;
  assign OVERRUN = st.ovr;
  assign SELECT_CONFLICT = st.select_conflict_flag;
  assign MODULE_ENABLE = st.en;
  assign MASTER_SELECT = st.master_select_alias;
  assign RX_DATA = st.rx_data;
  assign TX_IRQ = st.tx_irq;
  assign RX_ERR_IRQ = st.rx_irq;

endmodule
`default_nettype wire

/* File: verification/spie_core_assertions.sv */
// concurrent checks on the ports of the spi status and request block
`timescale 1ns/10ps
`default_nettype none
module spie_core_assertions
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CTRL_WR,
  input wire logic DATA_RD,
  input wire logic DATA_WR,
  input wire logic SS_N,
  input wire logic SCK_OE,
  input wire logic MOSI_OE,
  input wire logic MISO_OE,
  input wire logic TX_EMPTY,
  input wire logic RX_FULL,
  input wire logic OVERRUN,
  input wire logic SELECT_CONFLICT,
  input wire logic MODULE_ENABLE,
  input wire logic MASTER_SELECT,
  input wire spie_pkg::spie_byte_t RX_DATA,
  input wire logic TX_IRQ,
  input wire logic RX_ERR_IRQ
);
  import spie_pkg::*;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  tx_request_a: assert property (TX_IRQ |-> TX_EMPTY && MODULE_ENABLE)
    else $error("tx request without cause");
  err_request_a: assert property (RX_ERR_IRQ |-> RX_FULL || OVERRUN || SELECT_CONFLICT)
    else $error("rx request without cause");
  empty_clear_a: assert property ($fell(TX_EMPTY) |-> $past(DATA_WR))
    else $error("empty cleared without write");
  full_clear_a: assert property ($fell(RX_FULL) |-> $past(DATA_RD))
    else $error("full cleared without read");
  overrun_clear_a: assert property ($fell(OVERRUN) |-> $past(DATA_RD))
    else $error("overrun cleared without read");
  conflict_clear_a: assert property ($fell(SELECT_CONFLICT) |-> $past(CTRL_WR))
    else $error("conflict cleared without write");
  master_conflict_a: assert property ($rose(SELECT_CONFLICT) && MASTER_SELECT |->
    !MODULE_ENABLE && TX_EMPTY && !SCK_OE && $stable(MASTER_SELECT)) else $error("master fault");
  slave_conflict_a: assert property ($rose(SELECT_CONFLICT) && !MASTER_SELECT |->
    $stable(MODULE_ENABLE) && $stable(MASTER_SELECT)) else $error("slave fault");
  pin_direction_a: assert property (SCK_OE || MOSI_OE |-> MASTER_SELECT && !MISO_OE)
    else $error("pin direction clash");
  miso_float_a: assert property (SS_N [*5] |-> !MISO_OE)
    else $error("miso driven while deselected");
  overrun_hold_a: assert property (OVERRUN && !DATA_RD |=> $stable(RX_DATA))
    else $error("rx data changed in overrun");
  disabled_state_a: assert property (!MODULE_ENABLE |-> TX_EMPTY && !SCK_OE && !MISO_OE)
    else $error("disabled state wrong");
endmodule
bind spie_core spie_core_assertions u_chk (.*);
`default_nettype wire

/* File: verification/spie_far_slave.sv */
// far side model: a phase 0, polarity 0 slave on the serial link
`timescale 1ns/10ps
`default_nettype none
module spie_far_slave
(
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  input wire spie_pkg::spie_byte_t tx,
  output logic miso,
  output spie_pkg::spie_byte_t rx
);
  import spie_pkg::*;
  logic [2:0] k = 3'h0;
  // counts launch edges of the frame; a deselect rewinds to the first bit
  always @(negedge sck or posedge sel_n)
  begin
    if (sel_n)
      k <= 3'h0;
    else
      k <= k + 3'h1;
  end
  always @(posedge sck) if (!sel_n) rx <= {rx[6:0], mosi};
  // released line shows the inverse so a stale bit cannot pass
  assign miso = sel_n ? ~tx[~k] : tx[~k];
endmodule
`default_nettype wire

/* File: verification/spie_core_tb.sv */
// self-checking bench of the spi status and request block
`timescale 1ns/10ps
`default_nettype none
module spie_core_tb;
  import spie_pkg::*;
  logic clk = 0, nrst = 0, c_wr = 0, c_en = 0, c_ms = 0, c_ph = 0, s_wr = 0, s_ei = 0;
  logic s_mf = 0, s_rd = 0, d_rd = 0, d_wr = 0, sck = 0, mosi = 0, ss_n = 1, p_sel_n = 1;
  logic sck_o, mosi_o, miso_i, miso_oe, tx_e, rx_f, ovr, conf, en_o, ms_o, tx_irq, rx_irq;
  logic c_ie = 1, miso_o;
  spie_byte_t din = 8'h00, p_tx = 8'h00, p_rx, rx_d;
  int err_count = 0, cmp_count = 0, cyc = 0, seed = 61, m_full = 0, m_ovr = 0, sf, so;
  spie_byte_t m_data = 8'h00;
  spie_core #(.DIV(8)) u_dut (.CLK(clk), .NRST(nrst), .CTRL_WR(c_wr), .CTRL_ENABLE(c_en),
    .CTRL_MASTER(c_ms), .CTRL_CPOL(1'b0), .CTRL_CPHA(c_ph), .CTRL_TXIE(c_ie),
    .CTRL_RXIE(c_ie), .STAT_WR(s_wr), .STAT_ERROR_IRQ_ENABLE(s_ei), .STAT_SELECT_CONFLICT_ENABLE(s_mf), .STAT_RD(s_rd),
    .DATA_RD(d_rd), .DATA_WR(d_wr), .DATA_WDATA(din), .SCK_IN(sck), .SCK_OUT(sck_o),
    .SCK_OE(), .MOSI_IN(mosi), .MOSI_OUT(mosi_o), .MOSI_OE(), .MISO_IN(miso_i),
    .MISO_OUT(miso_o), .MISO_OE(miso_oe), .SS_N(ss_n), .TX_EMPTY(tx_e), .RX_FULL(rx_f),
    .OVERRUN(ovr), .SELECT_CONFLICT(conf), .MODULE_ENABLE(en_o), .MASTER_SELECT(ms_o),
    .RX_DATA(rx_d), .TX_IRQ(tx_irq), .RX_ERR_IRQ(rx_irq));
  spie_far_slave u_far (.sck(sck_o), .sel_n(p_sel_n), .mosi(mosi_o), .tx(p_tx),
    .miso(miso_i), .rx(p_rx));
  always #4 clk = ~clk;
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk_byte(string n, spie_byte_t e, spie_byte_t s);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_bit(string n, logic e, logic s);
    chk_byte(n, {7'h00, e}, {7'h00, s});
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
  endtask
  task automatic ctrl(logic e, logic m, logic p);
    c_en = e;
    c_ms = m;
    c_ph = p;
    pulse(c_wr);
  endtask
  task automatic sel_only();
    ss_n = 0;
    step(4);
    ss_n = 1;
    step(4);
  endtask
  // expected flags move only when the status read saw them set
  task automatic rd();
    pulse(s_rd);
    sf = m_full;
    so = m_ovr;
    pulse(d_rd);
    if (sf) m_full = 0;
    if (so) m_ovr = 0;
  endtask
  task automatic model(spie_byte_t v);
    if (m_ovr == 0 && m_full != 0)
      m_ovr = 1;
    else if (m_ovr == 0)
    begin
      m_full = 1;
      m_data = v;
    end
    chk_bit("rx full", m_full[0], rx_f);
    chk_bit("overrun", m_ovr[0], ovr);
    chk_byte("rx data", m_data, rx_d);
  endtask
  task automatic mxfer();
    spie_byte_t d;
    step(1);
    d = 8'($random(seed));
    p_tx = 8'($random(seed));
    p_sel_n = 0;
    din = d;
    pulse(d_wr);
    chk_bit("tx empty", 1'b0, tx_e);
    step(1);
    chk_bit("tx empty", 1'b1, tx_e);
    step(72);
    p_sel_n = 1;
    chk_byte("far rx", d, p_rx);
    model(p_tx);
  endtask
  // bit 7 is not presented before the first edge, so it is expected as zero and bits 6..0 as sent
  task automatic sxfer(spie_byte_t d);
    int i;
    spie_byte_t q;
    spie_byte_t t;
    t = 8'($random(seed));
    din = t;
    pulse(d_wr);
    step(1);
    chk_bit("tx empty", 1'b1, tx_e);
    ss_n = 0;
    step(4);
    din = ~t;
    pulse(d_wr);
    step(1);
    chk_bit("tx empty", 1'b0, tx_e);
    #23;
    for (i = 7; i >= 0; i--)
    begin
      mosi = d[i];
      #15;
      q[i] = miso_o;
      sck = 1;
      #15 sck = 0;
    end
    #40 ss_n = 1;
    mosi = ~mosi;
    step(6);
    chk_bit("tx empty", 1'b1, tx_e);
    chk_byte("slave out", {1'b0, t[6:0]}, q);
    model(d);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    #1 nrst = 1;
    chk_bit("tx empty", 1'b1, tx_e);
    s_ei = 1;
    s_mf = 1;
    pulse(s_wr);
    ctrl(1, 1, 0);
    chk_bit("tx irq", 1'b1, tx_irq);
    repeat (3) mxfer();
    rd();
    pulse(s_rd);
    chk_bit("overrun", 1'b0, ovr);
    chk_bit("rx full", 1'b0, rx_f);
    chk_byte("rx data", m_data, rx_d);
    ctrl(1, 0, 0);
    sxfer(8'($random(seed)));
    chk_bit("conflict", 1'b0, conf);
    chk_bit("miso oe", 1'b0, miso_oe);
    rd();
    sel_only();
    chk_bit("conflict", 1'b1, conf);
    chk_bit("enable", 1'b1, en_o);
    chk_bit("rx err irq", 1'b1, rx_irq);
    pulse(s_rd);
    ctrl(1, 0, 1);
    chk_bit("conflict", 1'b0, conf);
    sel_only();
    chk_bit("conflict", 1'b0, conf);
    ctrl(1, 1, 0);
    ss_n = 0;
    step(4);
    chk_bit("conflict", 1'b1, conf);
    chk_bit("enable", 1'b0, en_o);
    chk_bit("master", 1'b1, ms_o);
    chk_bit("tx irq", 1'b0, tx_irq);
    pulse(s_rd);
    ctrl(1, 1, 0);
    chk_bit("conflict", 1'b1, conf);
    s_mf = 0;
    pulse(s_wr);
    chk_bit("conflict", 1'b1, conf);
    ss_n = 1;
    step(3);
    pulse(s_rd);
    ctrl(0, 1, 0);
    chk_bit("conflict", 1'b0, conf);
    ctrl(1, 1, 0);
    ss_n = 0;
    step(4);
    chk_bit("conflict", 1'b0, conf);
    c_ie = 0;
    ctrl(1, 1, 0);
    chk_bit("tx irq", 1'b0, tx_irq);
    ss_n = 1;
    end_sim();
  end
endmodule
`default_nettype wire
